// ### verilog/mspd_pkg.sv
package mspd_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses on apb)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_BAUD = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_MODE_HI = 1;
    localparam int CTRL_RUN = 2;
    localparam int CTRL_REC = 3;
    localparam int CTRL_END = 4;
    localparam int CTRL_OVR = 5;
    localparam int CTRL_ARB = 6;
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_UART = 2'h1;
    localparam logic [1:0] MODE_MAST = 2'h2;
    localparam logic [1:0] MODE_SLAV = 2'h3;
    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_END = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_ARB = 2;
    localparam int IRQ_W = 3;
    // ------------------------------------------------------------
    // sizes and counts
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int BUF_W = 9;
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam logic [3:0] BIT_NINTH = 4'h8;
    localparam logic [1:0] UART_PRE = 2'h3;
    localparam logic [7:0] BAUD_RESET = 8'h00;
endpackage

// ### verilog/mspd_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts when stages two and three agree
module mspd_sync (
    input wire logic clk,     // system clock
    input wire logic rst_n,   // sync reset, low active
    input wire logic din,     // asynchronous pin
    output logic dout         // filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    // ------------------------------------------------------------
    // stage chain
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            dout <= 1'b1;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule

// ### verilog/mspd_baud.sv
`timescale 1ns/1ps
// 8-bit reload counter: a tick every (reload+1) cycles, a half-period tick per toggle
module mspd_baud #(
    parameter int W = 8       // reload width
) (
    input wire logic clk,           // system clock
    input wire logic rst_n,         // sync reset, low active
    input wire logic restart,       // reload now
    input wire logic [W-1:0] reload,// reload value
    output logic tick               // one-cycle pulse
);
    logic [W-1:0] cnt_reg;
    // ------------------------------------------------------------
    // down counter, reloaded at zero
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (restart) begin
            cnt_reg <= reload;
            tick <= 1'b0;
        end else if (cnt_reg == '0) begin
            cnt_reg <= reload;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg - 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// ### verilog/mspd_top.sv
`timescale 1ns/1ps
// How it works
// - shifter hidden, reached only via data buffer
// - data buffer nine bits, bit eight extra
// - transfer start copies buffer into shifter
// - transfer end copies shifter into buffer
// - ninth sampled bit stored in bit eight
// - serial clock from 8-bit reload counter
// - sync/master clock period 2 to 512
// - uart bit period 8 to 2048
// - master arbitration loss stops clocking at once
// - uart start on data falling edge
// - sync mode always shifts data in
// - slave raises interrupt at clock hold
module mspd_top (
    input wire logic clk,            // 250 MHz system clock
    input wire logic rst_n,          // sync reset, low active
    input wire logic psel,           // apb select
    input wire logic penable,        // apb enable
    input wire logic pwrite,         // apb direction
    input wire logic [7:0] paddr,    // apb byte address
    input wire logic [31:0] pwdata,  // apb write data
    output logic [31:0] prdata,      // apb read data
    output logic pready,             // apb ready
    output logic pslverr,            // apb error
    output logic irq,                // level interrupt
    input wire logic sck_in,         // clock line in
    output logic sck_out,            // clock line drive level
    output logic sck_oe_n,           // clock drive enable, low drives
    input wire logic sda_in,         // data line in
    output logic sda_out,            // data line drive level
    output logic sda_oe_n            // data drive enable, low drives
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_HOLD} mspd_state_type;
    mspd_state_type state_reg;
    logic [1:0] mode_reg;
    logic run_reg, rec_reg, end_reg, ovr_reg, arb_reg;
    logic [8:0] buf_reg;
    logic [7:0] baud_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_reg;
    logic [1:0] pre_reg;
    logic [2:0] stat_reg;
    logic [2:0] mask_reg;
    logic sck_s, sda_s, sck_d_reg, sda_d_reg;
    logic tick, half, restart;
    logic wr, rd, end_set, ovr_set, arb_set, go, sck_fall, sck_rise, sda_fall;
    logic out_bit;
    logic tx_bit_reg;
    logic [2:0] stat_set;
    logic [3:0] last_bit;
    logic shift_en;
    // uart frame: bit 0 start, 1..8 data, this one the stop bit
    localparam logic [3:0] BIT_STOP = mspd_pkg::BIT_NINTH + 4'h1;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    mspd_sync u_sck (.clk(clk), .rst_n(rst_n), .din(sck_in), .dout(sck_s));
    mspd_sync u_sda (.clk(clk), .rst_n(rst_n), .din(sda_in), .dout(sda_s));

    // edge detect on filtered pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            sck_d_reg <= sck_s;
            sda_d_reg <= sda_s;
        end
    end
    assign sck_fall = sck_d_reg & ~sck_s;
    assign sck_rise = ~sck_d_reg & sck_s;
    assign sda_fall = sda_d_reg & ~sda_s;

    // ------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------
    // tick every (baud+1) cycles is a half period: 2..512 per clock period
    mspd_baud #(.W(mspd_pkg::DATA_W)) u_baud (
        .clk(clk), .rst_n(rst_n), .restart(restart), .reload(baud_reg), .tick(tick)
    );
    // uart uses four ticks per half, giving 8..2048 per bit
    always_ff @(posedge clk) begin
        if (!rst_n || restart) begin
            pre_reg <= 2'h0;
        end else if (tick) begin
            pre_reg <= pre_reg + 2'h1;
        end
    end
    assign half = (mode_reg == mspd_pkg::MODE_UART) ? (tick && pre_reg == mspd_pkg::UART_PRE) : tick;

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    assign pslverr = psel & penable & ~(hit(paddr, mspd_pkg::ADDR_CTRL) | hit(paddr, mspd_pkg::ADDR_DATA) |
        hit(paddr, mspd_pkg::ADDR_BAUD) | hit(paddr, mspd_pkg::ADDR_STAT) | hit(paddr, mspd_pkg::ADDR_MASK));

    // read data latched in setup so it is a flop output in access
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, mspd_pkg::ADDR_CTRL)) begin
                prdata[6:0] <= {arb_reg, ovr_reg, end_reg, rec_reg, run_reg, mode_reg};
            end
            if (hit(paddr, mspd_pkg::ADDR_DATA)) begin
                prdata[8:0] <= buf_reg;
            end
            if (hit(paddr, mspd_pkg::ADDR_BAUD)) begin
                prdata[7:0] <= baud_reg;
            end
            if (hit(paddr, mspd_pkg::ADDR_STAT)) begin
                prdata[2:0] <= stat_reg;
            end
            if (hit(paddr, mspd_pkg::ADDR_MASK)) begin
                prdata[2:0] <= mask_reg;
            end
        end
    end

    // baud and mask registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            baud_reg <= mspd_pkg::BAUD_RESET;
            mask_reg <= 3'h0;
        end else if (wr) begin
            if (hit(paddr, mspd_pkg::ADDR_BAUD)) begin
                baud_reg <= pwdata[7:0];
            end
            if (hit(paddr, mspd_pkg::ADDR_MASK)) begin
                mask_reg <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status: set wins over write-one-to-clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_reg <= 3'h0;
        end else begin
            for (int i = 0; i < mspd_pkg::IRQ_W; i++) begin
                if (stat_set[i]) begin
                    stat_reg[i] <= 1'b1;
                end else if (wr && hit(paddr, mspd_pkg::ADDR_STAT) && pwdata[i]) begin
                    stat_reg[i] <= 1'b0;
                end
            end
        end
    end
    assign stat_set = {arb_set, ovr_set, end_set};
    assign irq = |(stat_reg & mask_reg);

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    // uart starts itself on a falling data edge; slave on a data fall while clock high with run clear; sync and master on software run
    assign go = (state_reg == ST_IDLE) && ((mode_reg == mspd_pkg::MODE_UART && sda_fall) ||
        (run_reg && !end_reg && mode_reg != mspd_pkg::MODE_SLAV) ||
        (mode_reg == mspd_pkg::MODE_SLAV && !run_reg && !end_reg && sck_s && sda_fall));
    assign restart = go;
    // receive sends all ones; open-drain lines let peer pull low
    assign out_bit = tx_bit_reg;
    // the bit on the wire is held in its own flop so a mid-bit shift cannot disturb it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_bit_reg <= 1'b1;
        end else if (go) begin
            tx_bit_reg <= rec_reg | buf_reg[mspd_pkg::DATA_W-1];
        end else if (state_reg == ST_HIGH && ((mode_reg != mspd_pkg::MODE_SLAV && half) ||
                     (mode_reg == mspd_pkg::MODE_SLAV && sck_fall))) begin
            tx_bit_reg <= rec_reg | shift_reg[mspd_pkg::DATA_W-1];
        end
    end
    // last bit slot per mode: sync eight, master nine clocks, uart through the stop bit
    assign last_bit = (mode_reg == mspd_pkg::MODE_SYNC) ? mspd_pkg::BITS_LAST :
        (mode_reg == mspd_pkg::MODE_UART) ? BIT_STOP : mspd_pkg::BIT_NINTH;
    assign shift_en = (mode_reg == mspd_pkg::MODE_UART) ? (bit_reg != '0 && bit_reg <= mspd_pkg::BIT_NINTH) :
        (bit_reg <= mspd_pkg::BITS_LAST);
    assign end_set = (state_reg != ST_IDLE) && (
        (mode_reg == mspd_pkg::MODE_SLAV && state_reg == ST_HIGH && sck_fall && bit_reg == mspd_pkg::BITS_LAST) ||
        (mode_reg != mspd_pkg::MODE_SLAV && state_reg == ST_HIGH && half && bit_reg == last_bit));
    assign arb_set = (mode_reg == mspd_pkg::MODE_MAST) && (state_reg == ST_LOW) && half &&
        out_bit && !sda_s && bit_reg <= mspd_pkg::BITS_LAST;
    assign ovr_set = end_set & end_reg;

    // shifter and bit counter; sampling on rising clock edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_reg <= 4'h0;
        end else if (go) begin
            shift_reg <= buf_reg[7:0];
            bit_reg <= 4'h0;
            state_reg <= ST_LOW;
        end else if (arb_set) begin
            state_reg <= ST_IDLE;
        end else if (mode_reg == mspd_pkg::MODE_SLAV) begin
            if (state_reg == ST_LOW && sck_rise) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                state_reg <= ST_HIGH;
            end else if (state_reg == ST_HIGH && sck_fall) begin
                bit_reg <= bit_reg + 4'h1;
                state_reg <= (bit_reg == mspd_pkg::BITS_LAST) ? ST_HOLD : ST_LOW;
            end else if (state_reg == ST_HOLD && !end_reg) begin
                state_reg <= ST_IDLE;
            end
        end else if (half) begin
            if (state_reg == ST_LOW) begin
                if (shift_en) begin
                    shift_reg <= {shift_reg[6:0], sda_s};
                end
                state_reg <= ST_HIGH;
            end else if (state_reg == ST_HIGH) begin
                bit_reg <= bit_reg + 4'h1;
                state_reg <= (bit_reg == last_bit) ? ST_IDLE : ST_LOW;
            end
        end
    end

    // data buffer: software write, transfer-end copy and ninth bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            buf_reg <= 9'h000;
        end else if (end_set && (mode_reg == mspd_pkg::MODE_SLAV || mode_reg == mspd_pkg::MODE_SYNC)) begin
            buf_reg[7:0] <= shift_reg;
        end else if (end_set) begin
            buf_reg <= {sda_s, shift_reg};
        end else if (wr && hit(paddr, mspd_pkg::ADDR_DATA)) begin
            buf_reg <= pwdata[8:0];
        end
    end

    // control register; hardware events win over software writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= mspd_pkg::MODE_SYNC;
            {run_reg, rec_reg, end_reg, ovr_reg, arb_reg} <= 5'h00;
        end else begin
            if (wr && hit(paddr, mspd_pkg::ADDR_CTRL)) begin
                mode_reg <= pwdata[mspd_pkg::CTRL_MODE_HI:mspd_pkg::CTRL_MODE_LO];
                run_reg <= pwdata[mspd_pkg::CTRL_RUN];
                rec_reg <= pwdata[mspd_pkg::CTRL_REC];
                end_reg <= pwdata[mspd_pkg::CTRL_END];
                ovr_reg <= pwdata[mspd_pkg::CTRL_OVR];
                arb_reg <= pwdata[mspd_pkg::CTRL_ARB];
            end
            if (go) begin
                run_reg <= 1'b1;
            end
            if (end_set) begin
                end_reg <= 1'b1;
                if (mode_reg == mspd_pkg::MODE_UART || mode_reg == mspd_pkg::MODE_SYNC) begin
                    run_reg <= 1'b0;
                end
            end
            if (ovr_set) begin
                ovr_reg <= 1'b1;
            end
            if (arb_set) begin
                run_reg <= 1'b0;
                arb_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // uart: start low at bit 0, data, stop high; others: data msb first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sda_out <= 1'b1;
            sck_out <= 1'b1;
        end else begin
            if (state_reg == ST_IDLE) begin
                sda_out <= 1'b1;
            end else if (mode_reg == mspd_pkg::MODE_UART) begin
                sda_out <= (bit_reg == 4'h0 && !rec_reg) ? 1'b0 : (bit_reg == BIT_STOP) ? 1'b1 : out_bit;
            end else begin
                sda_out <= out_bit;
            end
            sck_out <= !(state_reg == ST_HOLD || (mode_reg != mspd_pkg::MODE_SLAV && state_reg == ST_LOW));
        end
    end
    assign sda_oe_n = sda_out;
    assign sck_oe_n = (mode_reg == mspd_pkg::MODE_UART) ? 1'b1 : sck_out;

    a_slave_hold: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_reg == mspd_pkg::MODE_SLAV && end_set) |=> ##1 (state_reg == ST_HOLD && !sck_oe_n))
        else $error("slave did not hold clock after eighth");
    a_arb_stop: assert property (@(posedge clk) disable iff (!rst_n)
        arb_set |=> (state_reg == ST_IDLE && !run_reg && arb_reg))
        else $error("arbitration loss did not stop transfer");
    a_load_shift: assert property (@(posedge clk) disable iff (!rst_n)
        go |=> shift_reg == $past(buf_reg[7:0]))
        else $error("shifter not loaded at start");
    a_end_copy: assert property (@(posedge clk) disable iff (!rst_n)
        (end_set && mode_reg == mspd_pkg::MODE_UART) |=> buf_reg == {$past(sda_s), $past(shift_reg)})
        else $error("ninth bit not stored");
    a_end_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (end_set && mode_reg == mspd_pkg::MODE_UART) |=> end_reg && !run_reg)
        else $error("uart end flags wrong");
    a_uart_auto: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_IDLE && mode_reg == mspd_pkg::MODE_UART && sda_fall) |=> run_reg && state_reg == ST_LOW)
        else $error("uart did not start on falling edge");
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        (end_set && mask_reg[mspd_pkg::IRQ_END]) |=> irq)
        else $error("interrupt not raised");
    a_sync_rx: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_reg == mspd_pkg::MODE_SYNC && state_reg == ST_LOW && half && bit_reg < mspd_pkg::BIT_NINTH)
        |=> shift_reg[0] == $past(sda_s))
        else $error("sync mode did not shift in");
endmodule

// ### dv/mspd_peer.sv
`timescale 1ns/1ps
// far-side serial peer: open-drain pulls only, so a released line floats up to the pull-up level
module mspd_peer #(
    parameter int UART_BIT = 64,   // uart bit time in ns
    parameter int LINK_HALF = 40   // half period of the link clock it makes
) (
    input wire logic sck_line,     // resolved clock line
    input wire logic sda_line,     // resolved data line
    output logic sck_pull_n,       // low pulls the clock line down
    output logic sda_pull_n        // low pulls the data line down
);
    int rises;
    realtime last_rise;
    realtime sck_period;
    // idle: both lines released, no clock outside frames
    initial begin
        sck_pull_n = 1'h1;
        sda_pull_n = 1'h1;
        rises = 0;
        last_rise = 0;
    end
    // clock edge statistics, period taken between consecutive rises
    always @(posedge sck_line) begin
        rises++;
        if (last_rise > 0) begin
            sck_period = $realtime - last_rise;
        end
        last_rise = $realtime;
    end
    task automatic clear_counts();
        rises = 0;
        last_rise = 0;
        sck_period = 0;
    endtask
    // samples mid-bit, msb first, then the stop level
    task automatic uart_recv(output logic [7:0] b, output logic stop);
        @(negedge sda_line);
        #(UART_BIT / 2);
        for (int i = 0; i < 8; i++) begin
            #(UART_BIT);
            b = {b[6:0], sda_line};
        end
        #(UART_BIT);
        stop = sda_line;
    endtask
    task automatic uart_send(input logic [7:0] b);
        sda_pull_n = 1'h0;
        #(UART_BIT);
        for (int i = 0; i < 8; i++) begin
            sda_pull_n = b[7-i];
            #(UART_BIT);
        end
        sda_pull_n = 1'h1;
        #(UART_BIT);
    endtask
    task automatic hold_sda(input logic level);
        sda_pull_n = level;
    endtask
    // collides on purpose: pulls data low once the master's first clock goes low
    task automatic grab_on_first_fall();
        @(negedge sck_line);
        sda_pull_n = 1'h0;
    endtask
    // acts as bus master: start with clock high, eight data clocks then a ninth, data moved only while clock low
    task automatic link_byte(input logic [7:0] b);
        sda_pull_n = 1'h0;
        #(LINK_HALF);
        for (int i = 0; i < 8; i++) begin
            sck_pull_n = 1'h0;
            #(LINK_HALF / 2);
            sda_pull_n = b[7-i];
            #(LINK_HALF / 2);
            sck_pull_n = 1'h1;
            #(LINK_HALF);
        end
        sck_pull_n = 1'h0;
        #(LINK_HALF / 2);
        sda_pull_n = 1'h1;
        #(LINK_HALF / 2);
        sck_pull_n = 1'h1;
    endtask
endmodule

// ### dv/test_multimode_serial_port_datapath.sv
`timescale 1ns/1ps
// self-checking bench: register table, then transfers in all four modes
module test_multimode_serial_port_datapath;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic err;
    } mspd_row_type;
    localparam int BAUD_SET = 1;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sck_out, sck_oe_n, sda_out, sda_oe_n, sck_pull_n, sda_pull_n, rerr, rx_stop;
    logic [7:0] rx_byte;
    int miscompares = 0;
    int check_count = 0;
    int cnt;
    mspd_row_type rows [10];
    // wired-and lines with pull-ups: whoever pulls low wins
    logic sck_line;
    logic sda_line;
    assign sck_line = sck_oe_n & sck_pull_n;
    assign sda_line = sda_oe_n & sda_pull_n;
    mspd_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .sck_in(sck_line),
        .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
    mspd_peer #(.UART_BIT(8 * (BAUD_SET + 1) * 4)) u_peer (.sck_line(sck_line),
        .sda_line(sda_line), .sck_pull_n(sck_pull_n), .sda_pull_n(sda_pull_n));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // bus and check helpers
    // ----------------------------------------
    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait, the limit only guards against a hang
    task automatic wait_irq(input int limit);
        cnt = 0;
        while (irq !== 1'h1 && cnt < limit) begin
            @(posedge clk);
            cnt++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        close_out();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{1'h0, mspd_pkg::ADDR_CTRL, 32'h0, 32'h0, 1'h0}, '{1'h0, mspd_pkg::ADDR_DATA, 32'h0, 32'h0, 1'h0},
            '{1'h0, mspd_pkg::ADDR_BAUD, 32'h0, {24'h0, mspd_pkg::BAUD_RESET}, 1'h0},
            '{1'h0, mspd_pkg::ADDR_STAT, 32'h0, 32'h0, 1'h0}, '{1'h0, mspd_pkg::ADDR_MASK, 32'h0, 32'h0, 1'h0},
            '{1'h1, mspd_pkg::ADDR_DATA, 32'hFFFFFFFF, 32'h1FF, 1'h0},
            '{1'h1, mspd_pkg::ADDR_BAUD, 32'hFFFFFFA5, 32'hA5, 1'h0},
            '{1'h1, mspd_pkg::ADDR_MASK, 32'hFFFFFFFF, 32'h7, 1'h0}, '{1'h1, 8'h14, 32'hFFFFFFFF, 32'h0, 1'h1},
            '{1'h1, mspd_pkg::ADDR_BAUD, 32'(BAUD_SET), 32'(BAUD_SET), 1'h0}};
        rst_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        // reset values, widths and the unmapped slot, one row at a time
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                apb(1'h1, rows[i].addr, rows[i].wdata);
            end
            apb(1'h0, rows[i].addr, 32'h0);
            chk("prdata", rows[i].exp, rd);
            chk("pslverr", {31'h0, rows[i].err}, {31'h0, rerr});
        end
        chk("irq idle", 32'h0, {31'h0, irq});
        $display("test registers done");
        // uart send: the wire echoes into the shifter, so the buffer gets the byte and the stop level
        apb(1'h1, mspd_pkg::ADDR_DATA, 32'h5A);
        fork
            apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h5);
            u_peer.uart_recv(rx_byte, rx_stop);
        join
        wait_irq(200);
        chk("uart byte", 32'h5A, {24'h0, rx_byte});
        chk("uart stop", 32'h1, {31'h0, rx_stop});
        chk("uart irq", 32'h1, {31'h0, irq});
        apb(1'h0, mspd_pkg::ADDR_CTRL, 32'h0);
        chk("uart ctrl", 32'h11, rd);
        apb(1'h0, mspd_pkg::ADDR_DATA, 32'h0);
        chk("uart data", 32'h15A, rd);
        apb(1'h1, mspd_pkg::ADDR_STAT, 32'h7);
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h9);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("test uart send done");
        // uart receive started only by the falling start edge
        u_peer.uart_send(8'hC3);
        wait_irq(200);
        chk("rx irq", 32'h1, {31'h0, irq});
        apb(1'h0, mspd_pkg::ADDR_DATA, 32'h0);
        chk("rx data", 32'h1C3, rd);
        apb(1'h0, mspd_pkg::ADDR_CTRL, 32'h0);
        chk("rx end run", 32'h10, rd & 32'h14);
        apb(1'h1, mspd_pkg::ADDR_STAT, 32'h7);
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h0);
        $display("test uart receive done");
        // sync send with the peer holding data low: the buffer must come back all zero
        apb(1'h1, mspd_pkg::ADDR_DATA, 32'h96);
        u_peer.clear_counts();
        u_peer.hold_sda(1'h0);
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h4);
        wait_irq(300);
        u_peer.hold_sda(1'h1);
        apb(1'h0, mspd_pkg::ADDR_DATA, 32'h0);
        chk("sync data", 32'h0, rd);
        chk("sync period", 32'(2 * (BAUD_SET + 1) * 4), 32'(int'(u_peer.sck_period)));
        apb(1'h1, mspd_pkg::ADDR_STAT, 32'h7);
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h0);
        $display("test sync done");
        // master sending ones while the peer pulls data low: lost at clock one
        apb(1'h1, mspd_pkg::ADDR_BAUD, 32'h7);
        apb(1'h1, mspd_pkg::ADDR_DATA, 32'hFF);
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h2);
        u_peer.clear_counts();
        fork
            apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h6);
            u_peer.grab_on_first_fall();
        join
        repeat (200) @(posedge clk);
        chk("arb rises", 32'h1, 32'(u_peer.rises));
        apb(1'h0, mspd_pkg::ADDR_CTRL, 32'h0);
        chk("arb ctrl", 32'h40, rd & 32'h44);
        chk("arb irq", 32'h1, {31'h0, irq});
        u_peer.hold_sda(1'h1);
        apb(1'h1, mspd_pkg::ADDR_STAT, 32'h7);
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'h0);
        $display("test master done");
        // slave receive: clock held low after the eighth fall until end is cleared
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'hB);
        u_peer.link_byte(8'hA6);
        wait_irq(100);
        chk("slave irq", 32'h1, {31'h0, irq});
        chk("slave hold", 32'h0, {31'h0, sck_oe_n});
        apb(1'h0, mspd_pkg::ADDR_DATA, 32'h0);
        chk("slave data", 32'hA6, rd & 32'hFF);
        apb(1'h1, mspd_pkg::ADDR_STAT, 32'h7);
        apb(1'h1, mspd_pkg::ADDR_CTRL, 32'hF);
        repeat (8) @(posedge clk);
        chk("slave release", 32'h1, {31'h0, sck_oe_n});
        $display("test slave done");
        close_out();
    end
endmodule
